// File: core/wakeup_pkg.sv
// Constants, register map and state types of the stop-mode periodic wakeup unit
package wakeup_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFS_PORT_A = 5'h00;
    localparam logic [4:0] OFS_KSC    = 5'h04;
    localparam logic [4:0] OFS_KEN    = 5'h08;
    localparam logic [4:0] OFS_CFG1   = 5'h0c;
    localparam logic [4:0] OFS_CFG2   = 5'h10;
    localparam logic [4:0] OFS_ISTS   = 5'h14;
    localparam logic [4:0] OFS_IMSK   = 5'h18;

    // Field positions
    localparam int PA_LATCH_BIT    = 6;
    localparam int KSC_FLAG_BIT    = 3;
    localparam int KSC_ACK_BIT     = 2;
    localparam int KSC_MASK_BIT    = 1;
    localparam int KEN_WAKE_EN_BIT = 6;
    localparam int CFG1_RATE_BIT   = 0;
    localparam int CFG2_KEEP_BIT   = 0;
    localparam int IRQ_OVF_BIT     = 0;
    localparam int IRQ_LATCH_BIT   = 1;

    // Counter width and default overflow counts, in source clock edges
    localparam int              CNT_W           = 16;
    localparam logic [15:0]     SHORT_COUNT_DEF = 16'h0200;
    localparam logic [15:0]     LONG_COUNT_DEF  = 16'h4000;
    localparam logic [15:0]     CNT_ZERO        = 16'h0000;

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    typedef struct packed {
        logic        run;
        logic        keep;
        logic        rate;
    } wake_cfg_t;

    typedef struct packed {
        logic [15:0] count;
        logic        tick_prev;
        logic        ovf;
    } cnt_state_t;

    typedef struct packed {
        logic        latch;
        logic        wake_en;
        logic        mask;
        logic        rate_sel;
        logic        osc_keep;
        logic [1:0]  sts;
        logic [1:0]  imsk;
        logic        bus_done;
        logic [7:0]  rdata;
        logic        wake_req;
        logic        vec_irq;
        logic        stop_exit;
        logic        irq;
    } main_state_t;

    // Every control bit comes up cleared
    localparam sync_state_t SYNC_RST = '0;
    localparam cnt_state_t  CNT_RST  = '0;
    localparam main_state_t MAIN_RST = '0;

endpackage : wakeup_pkg

// File: core/level_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module level_sync
    import wakeup_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);

    sync_state_t st;
    sync_state_t next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = i_async;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            st <= SYNC_RST;
        else
            st <= next_st;
    end

    assign o_sync = st.s2;

endmodule : level_sync

// File: core/wake_counter.sv
// Wakeup period counter stepping on edges of the selected slow source
`timescale 1ns/1ps
module wake_counter
    import wakeup_pkg::*;
#(
    parameter logic [15:0] SHORT_COUNT = SHORT_COUNT_DEF,
    parameter logic [15:0] LONG_COUNT  = LONG_COUNT_DEF
)
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_rc_lvl,
    input  wire logic       i_bus_lvl,
    input  wire wake_cfg_t  i_cfg,
    output logic            o_overflow,
    output logic [15:0]     o_count
);

    cnt_state_t  st;
    cnt_state_t  next_st;
    logic        tick_src;
    logic [15:0] limit;

    always_comb
    begin
        next_st   = st;
        tick_src  = i_cfg.keep ? i_bus_lvl : i_rc_lvl;
        limit     = i_cfg.rate ? (SHORT_COUNT - 16'h0001) : (LONG_COUNT - 16'h0001);
        next_st.tick_prev = tick_src;
        next_st.ovf       = 1'b0;
        // Held at zero outside stop so each entry starts a full period
        if (!i_cfg.run)
            next_st.count = CNT_ZERO;
        else if (tick_src && !st.tick_prev)
        begin
            if (st.count >= limit)
            begin
                next_st.count = CNT_ZERO;
                next_st.ovf   = 1'b1;
            end
            else
                next_st.count = st.count + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            st <= CNT_RST;
        else
            st <= next_st;
    end

    assign o_overflow = st.ovf;
    assign o_count    = st.count;

endmodule : wake_counter

// File: core/periodic_wakeup_unit.sv
// Stop-mode periodic wakeup unit with Avalon-MM registers and keypad hand-off
//
// Notes on behaviour
// - Stop mode entry enables wakeup generation
// - Oscillator and counter idle outside stop
// - Request pulse with enable set latches
// - Latch reads at port A bit 6
// - Keep-on bit selects doubled bus clock
// - Overflow latches request, forwarded to keypad
// - Request serviced only while enable set
// - Rate select one short, zero long
// - Acknowledge write or reset clears latch
// - Enable never alters latch read value
// - Wakeup shares the keypad interrupt vector
// - Stop exit only while keypad mask clear
`timescale 1ns/1ps
module periodic_wakeup_unit
    import wakeup_pkg::*;
#(
    parameter logic [15:0] SHORT_COUNT = SHORT_COUNT_DEF,
    parameter logic [15:0] LONG_COUNT  = LONG_COUNT_DEF
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_stop_mode,
    input  wire logic        i_wakeup_rc_oscillator,
    input  wire logic        i_doubled_bus_clock,
    input  wire logic        i_keypad_pin_flag,
    output logic             o_wakeup_request,
    output logic             o_keypad_vector_irq,
    output logic             o_stop_exit,
    output logic             o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    main_state_t st;
    main_state_t next_st;
    wake_cfg_t   cfg;
    logic        rc_lvl;
    logic        bus_lvl;
    logic        ovf;
    logic [15:0] count;
    logic        req;
    logic        take;
    logic        wr_hit;
    logic        ack_wr;
    logic        sts_rd;
    logic        latch_set;
    logic        serviced;
    logic        sel_lvl;
    logic [1:0]  events;
    logic [1:0]  sts_clr;
    logic [7:0]  rd_val;

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock sources and the period counter

    level_sync u_rc_sync
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_wakeup_rc_oscillator),
        .o_sync  (rc_lvl)
    );

    level_sync u_bus_sync
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_doubled_bus_clock),
        .o_sync  (bus_lvl)
    );

    // One driver for the whole carrier struct
    assign cfg = '{
        run:  i_stop_mode,
        keep: st.osc_keep,
        rate: st.rate_sel
    };

    wake_counter #(
        .SHORT_COUNT (SHORT_COUNT),
        .LONG_COUNT  (LONG_COUNT)
    ) u_counter
    (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_rc_lvl   (rc_lvl),
        .i_bus_lvl  (bus_lvl),
        .i_cfg      (cfg),
        .o_overflow (ovf),
        .o_count    (count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state, effects land on the completing edge

    assign req     = i_avs_read | i_avs_write;
    assign take    = req & st.bus_done;
    assign wr_hit  = take & i_avs_write & i_avs_byteenable[0];
    assign ack_wr  = wr_hit & (i_avs_address == OFS_KSC) & i_avs_writedata[KSC_ACK_BIT];
    assign sts_rd  = take & i_avs_read & (i_avs_address == OFS_ISTS);
    assign sel_lvl = st.osc_keep ? bus_lvl : rc_lvl;

    always_comb
    begin
        rd_val = 8'h00;
        case (i_avs_address)
            OFS_PORT_A:
                rd_val[PA_LATCH_BIT] = st.latch;
            OFS_KSC:
            begin
                rd_val[KSC_FLAG_BIT] = i_keypad_pin_flag;
                rd_val[KSC_MASK_BIT] = st.mask;
            end
            OFS_KEN:
                rd_val[KEN_WAKE_EN_BIT] = st.wake_en;
            OFS_CFG1:
                rd_val[CFG1_RATE_BIT] = st.rate_sel;
            OFS_CFG2:
                rd_val[CFG2_KEEP_BIT] = st.osc_keep;
            OFS_ISTS:
                rd_val[1:0] = st.sts;
            OFS_IMSK:
                rd_val[1:0] = st.imsk;
            default:
                rd_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_st   = st;
        latch_set = ovf & st.wake_en;
        serviced  = st.latch & st.wake_en;
        events    = 2'h0;
        events[IRQ_OVF_BIT]   = ovf;
        events[IRQ_LATCH_BIT] = latch_set;
        // Only bits that the master actually saw are cleared by its read
        sts_clr   = sts_rd ? st.rdata[1:0] : 2'h0;

        next_st.bus_done = req & ~st.bus_done;
        if (req && !st.bus_done)
            next_st.rdata = rd_val;

        if (wr_hit)
        begin
            case (i_avs_address)
                OFS_KSC:
                    next_st.mask = i_avs_writedata[KSC_MASK_BIT];
                OFS_KEN:
                    next_st.wake_en = i_avs_writedata[KEN_WAKE_EN_BIT];
                OFS_CFG1:
                    next_st.rate_sel = i_avs_writedata[CFG1_RATE_BIT];
                OFS_CFG2:
                    next_st.osc_keep = i_avs_writedata[CFG2_KEEP_BIT];
                OFS_IMSK:
                    next_st.imsk = i_avs_writedata[1:0];
                default:
                    next_st.imsk = st.imsk;
            endcase
        end

        // Set beats acknowledge in the same cycle
        next_st.latch = latch_set | (st.latch & ~ack_wr);
        next_st.sts   = (st.sts & ~sts_clr) | events;

        next_st.wake_req  = serviced;
        // Wakeup rides on the keypad vector, gated by the keypad mask
        next_st.vec_irq   = (i_keypad_pin_flag | serviced) & ~st.mask;
        next_st.stop_exit = (i_keypad_pin_flag | serviced) & ~st.mask & i_stop_mode;
        next_st.irq       = |(st.sts & st.imsk);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            st <= MAIN_RST;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_avs_waitrequest   = req & ~st.bus_done;
    assign o_avs_readdata      = {24'h000000, st.rdata};
    assign o_wakeup_request    = st.wake_req;
    assign o_keypad_vector_irq = st.vec_irq;
    assign o_stop_exit         = st.stop_exit;
    assign o_irq               = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    property p_ovf_in_stop;
        ovf |-> $past(i_stop_mode);
    endproperty
    a_ovf_in_stop: assert property (p_ovf_in_stop)
        else $error("overflow outside stop mode");

    property p_idle_run;
        !i_stop_mode |=> (count == CNT_ZERO) && !ovf;
    endproperty
    a_idle_run: assert property (p_idle_run)
        else $error("counter active in run mode");

    property p_latch_on_req;
        (ovf && st.wake_en) |=> st.latch;
    endproperty
    a_latch_on_req: assert property (p_latch_on_req)
        else $error("enabled request pulse not latched");

    property p_port_a_read;
        (i_avs_read && st.bus_done && (i_avs_address == OFS_PORT_A))
            |-> (o_avs_readdata == {24'h000000, 1'b0, $past(st.latch), 6'h00});
    endproperty
    a_port_a_read: assert property (p_port_a_read)
        else $error("port A read does not show latch alone");

    property p_src_select;
        (i_stop_mode && $past(i_stop_mode) && !ovf && (count != $past(count)))
            |-> ($past(sel_lvl) && !$past(sel_lvl, 2));
    endproperty
    a_src_select: assert property (p_src_select)
        else $error("counter stepped without edge of selected source");

    property p_forward;
        (ovf && st.wake_en) ##1 st.wake_en |=> o_wakeup_request;
    endproperty
    a_forward: assert property (p_forward)
        else $error("overflow request not forwarded");

    property p_service_gate;
        o_wakeup_request |-> $past(st.wake_en) && $past(st.latch);
    endproperty
    a_service_gate: assert property (p_service_gate)
        else $error("request forwarded while disabled");

    property p_period;
        ovf |-> ($past(count) == ($past(st.rate_sel) ?
                 (SHORT_COUNT - 16'h0001) : (LONG_COUNT - 16'h0001)));
    endproperty
    a_period: assert property (p_period)
        else $error("overflow at wrong count");

    property p_ack_clear;
        (ack_wr && !latch_set) |=> !st.latch;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("acknowledge did not clear latch");

    property p_read_no_enable;
        (i_avs_read && st.bus_done && (i_avs_address == OFS_PORT_A) && !$past(st.wake_en))
            |-> (o_avs_readdata[PA_LATCH_BIT] == $past(st.latch));
    endproperty
    a_read_no_enable: assert property (p_read_no_enable)
        else $error("latch read hidden by enable");

    property p_shared_vector;
        (st.latch && st.wake_en && !st.mask) |=> o_keypad_vector_irq;
    endproperty
    a_shared_vector: assert property (p_shared_vector)
        else $error("wakeup missing on keypad vector");

    property p_stop_exit_mask;
        o_stop_exit |-> !$past(st.mask) && $past(i_stop_mode);
    endproperty
    a_stop_exit_mask: assert property (p_stop_exit_mask)
        else $error("stop exit while keypad masked");

    property p_entry_zero;
        $rose(i_stop_mode) |-> (count == CNT_ZERO);
    endproperty
    a_entry_zero: assert property (p_entry_zero)
        else $error("counter not zero at stop entry");

    property p_latch_hold;
        (st.latch && !ack_wr) |=> st.latch;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch dropped without acknowledge");

    property p_irq_level;
        (|(st.sts & st.imsk)) |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("unmasked status without interrupt");

    property p_irq_quiet;
        !(|(st.sts & st.imsk)) |=> !o_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt without unmasked status");

    property p_one_wait;
        o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("more than one wait state");

    property p_readdata_upper;
        o_avs_readdata[31:8] == 24'h000000;
    endproperty
    a_readdata_upper: assert property (p_readdata_upper)
        else $error("upper read data bits not zero");

    property p_sts_ovf_set;
        ovf |=> st.sts[IRQ_OVF_BIT];
    endproperty
    a_sts_ovf_set: assert property (p_sts_ovf_set)
        else $error("overflow status not set");

    property p_sts_latch_set;
        latch_set |=> st.sts[IRQ_LATCH_BIT];
    endproperty
    a_sts_latch_set: assert property (p_sts_latch_set)
        else $error("latch event status not set");

    property p_sts_sticky;
        (st.sts[IRQ_OVF_BIT] && !sts_rd) |=> st.sts[IRQ_OVF_BIT];
    endproperty
    a_sts_sticky: assert property (p_sts_sticky)
        else $error("status bit dropped without read");

    property p_byte_refused;
        (take && i_avs_write && !i_avs_byteenable[0])
            |=> ($stable(st.wake_en) && $stable(st.mask) && $stable(st.imsk));
    endproperty
    a_byte_refused: assert property (p_byte_refused)
        else $error("write without low byte enable took effect");

    property p_vec_mask;
        st.mask |=> !o_keypad_vector_irq;
    endproperty
    a_vec_mask: assert property (p_vec_mask)
        else $error("keypad vector raised while masked");

endmodule : periodic_wakeup_unit

// File: bench/keypad_cpu_model.sv
// Keypad interrupt logic and CPU stop-mode handling facing the wakeup unit
`timescale 1ns/1ps
module keypad_cpu_model
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_enter,
    input  wire logic       i_leave,
    input  wire logic       i_vector_irq,
    input  wire logic       i_stop_exit,
    output logic            o_stop_mode,
    output logic [7:0]      o_vec_count
);
    logic vec_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // The CPU leaves stop only when the unit asks or the bench forces it
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_stop_mode <= 1'b0;
            o_vec_count <= 8'h00;
            vec_prev    <= 1'b0;
        end
        else
        begin
            if (i_enter)
                o_stop_mode <= 1'b1;
            else if (i_leave || i_stop_exit)
                o_stop_mode <= 1'b0;
            vec_prev <= i_vector_irq;
            // One vector fetch per rising request, shared with pin interrupts
            if (i_vector_irq && !vec_prev)
                o_vec_count <= o_vec_count + 8'h01;
        end
    end
endmodule : keypad_cpu_model

// File: bench/periodic_wakeup_unit_tb.sv
// Register-level testbench of the stop-mode periodic wakeup unit
`timescale 1ns/1ps
module periodic_wakeup_unit_tb;
    import wakeup_pkg::*;
    localparam logic [15:0] SHORT_N = 16'h0004;
    localparam logic [15:0] LONG_N  = 16'h0008;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'hf;
    logic        rc = 1'b0;
    logic        busclk = 1'b0;
    logic        pin = 1'b0;
    logic        enter = 1'b0;
    logic        leave = 1'b0;
    logic [31:0] rdata;
    logic        wait_req;
    logic        stop_mode;
    logic        wake_req;
    logic        vec_irq;
    logic        stop_exit;
    logic        irq;
    logic [7:0]  vec_count;
    int          bad_count = 0;
    int          n_compared = 0;
    int          n;
    int          lo;
    int          hi;
    logic [7:0]  vc;
    logic        cfg_rate [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic        cfg_keep [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    periodic_wakeup_unit #(.SHORT_COUNT(SHORT_N), .LONG_COUNT(LONG_N)) dut (
        .i_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_stop_mode(stop_mode),
        .i_wakeup_rc_oscillator(rc), .i_doubled_bus_clock(busclk),
        .i_keypad_pin_flag(pin), .o_wakeup_request(wake_req),
        .o_keypad_vector_irq(vec_irq), .o_stop_exit(stop_exit), .o_irq(irq));

    keypad_cpu_model partner (
        .i_clk(clk), .i_rst(rst), .i_enter(enter), .i_leave(leave),
        .i_vector_irq(vec_irq), .i_stop_exit(stop_exit),
        .o_stop_mode(stop_mode), .o_vec_count(vec_count));

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: slow sources toggle on falling fast edges, between the rising ones, in fixed phase
    initial
    begin
        forever #4 clk = ~clk;
    end
    always #40 rc = ~rc;
    always #24 busclk = ~busclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and compare tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_cycle(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= {24'h0, d};
        rd  <= !w;
        wr  <= w;
        // No local limit: a missing answer is left to the watchdog
        do
        begin
            @(posedge clk);
        end
        while (wait_req !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus_cycle

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus_cycle(a, 1'b0, 8'h00);
        check(rdata, exp);
    endtask : rd_chk

    // One-cycle request to the CPU model: 1 enters stop, 0 leaves it
    task automatic pulse(input logic to_stop);
        @(posedge clk);
        if (to_stop)
            enter <= 1'b1;
        else
            leave <= 1'b1;
        @(posedge clk);
        enter <= 1'b0;
        leave <= 1'b0;
    endtask : pulse

    // Bounded wait for the forwarded request, counted from stop entry
    task automatic wait_wake(output int c);
        c = 0;
        while (wake_req !== 1'b1 && c < 300)
        begin
            @(posedge clk);
            c++;
        end
    endtask : wait_wake

    task automatic finish_test;
        $display("counts: %0d compared, %0d wrong", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_PORT_A, 32'h0);
        rd_chk(OFS_KSC, 32'h0);
        rd_chk(OFS_KEN, 32'h0);
        rd_chk(OFS_CFG1, 32'h0);
        rd_chk(OFS_CFG2, 32'h0);
        rd_chk(OFS_ISTS, 32'h0);
        rd_chk(OFS_IMSK, 32'h0);
        bus_cycle(OFS_PORT_A, 1'b1, 8'hff);
        rd_chk(OFS_PORT_A, 32'h0);
        bus_cycle(5'h1c, 1'b1, 8'hff);
        rd_chk(5'h1c, 32'h0);
        be <= 4'h0;
        bus_cycle(OFS_KEN, 1'b1, 8'h40);
        be <= 4'hf;
        rd_chk(OFS_KEN, 32'h0);
        $display("test reset_map done");
        // Counter must not run while the CPU is awake
        bus_cycle(OFS_KEN, 1'b1, 8'h40);
        bus_cycle(OFS_CFG1, 1'b1, 8'h01);
        repeat (100) @(posedge clk);
        rd_chk(OFS_ISTS, 32'h0);
        rd_chk(OFS_PORT_A, 32'h0);
        $display("test idle_run done");
        bus_cycle(OFS_IMSK, 1'b1, 8'h03);
        for (int c = 0; c < 4; c++)
        begin
            bus_cycle(OFS_CFG1, 1'b1, {7'h0, cfg_rate[c]});
            bus_cycle(OFS_CFG2, 1'b1, {7'h0, cfg_keep[c]});
            hi = cfg_keep[c] ? 6 : 10;
            lo = cfg_rate[c] ? int'(SHORT_N) : int'(LONG_N);
            vc = vec_count;
            pulse(1'b1);
            wait_wake(n);
            check(n >= (lo - 1) * hi && n <= lo * hi + 8, 1'b1);
            repeat (3) @(posedge clk);
            check(stop_mode, 1'b0);
            check(vec_count, vc + 8'h01);
            check(irq, 1'b1);
            rd_chk(OFS_PORT_A, 32'h40);
            rd_chk(OFS_ISTS, 32'h3);
            rd_chk(OFS_ISTS, 32'h0);
            check(irq, 1'b0);
            bus_cycle(OFS_KSC, 1'b1, 8'h04);
            rd_chk(OFS_PORT_A, 32'h0);
            check(wake_req, 1'b0);
        end
        $display("test periods done");
        // Masked keypad: latch sets but the CPU stays stopped
        bus_cycle(OFS_KSC, 1'b1, 8'h02);
        pulse(1'b1);
        wait_wake(n);
        check(n < 300, 1'b1);
        repeat (4) @(posedge clk);
        check(vec_irq, 1'b0);
        check(stop_mode, 1'b1);
        bus_cycle(OFS_KEN, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        check(wake_req, 1'b0);
        rd_chk(OFS_PORT_A, 32'h40);
        pulse(1'b0);
        repeat (20) @(posedge clk);
        rd_chk(OFS_PORT_A, 32'h40);
        // Overflow with the request disabled leaves the latch clear
        rd_chk(OFS_ISTS, 32'h3);
        bus_cycle(OFS_KSC, 1'b1, 8'h06);
        rd_chk(OFS_PORT_A, 32'h0);
        bus_cycle(OFS_IMSK, 1'b1, 8'h02);
        pulse(1'b1);
        repeat (80) @(posedge clk);
        check(wake_req, 1'b0);
        check(irq, 1'b0);
        rd_chk(OFS_ISTS, 32'h1);
        rd_chk(OFS_PORT_A, 32'h0);
        pulse(1'b0);
        $display("test mask_enable done");
        // Reset after the run reads back a clear latch and a cleared keypad mask
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_PORT_A, 32'h0);
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        check(vec_irq, 1'b1);
        rd_chk(OFS_KSC, 32'h8);
        bus_cycle(OFS_KSC, 1'b1, 8'h02);
        repeat (2) @(posedge clk);
        check(vec_irq, 1'b0);
        pin <= 1'b0;
        $display("test reset_pin done");
        finish_test();
    end
endmodule : periodic_wakeup_unit_tb
